// file: logic/rec_defines.vh
`ifndef REC_DEFINES_VH
`define REC_DEFINES_VH

// register offsets within the 64-address board window
`define REC_OFS_CAPTURE     6'h1E
`define REC_OFS_INT_ENABLE  6'h1E
`define REC_OFS_STATUS      6'h16
`define REC_OFS_POLARITY    6'h22
`define REC_OFS_DISARM      6'h24
`define REC_OFS_ARM         6'h26

// status word field
`define REC_STATUS_REQ_BIT  11

// reset values
`define REC_RST_POLARITY    16'h0000
`define REC_RST_ARM         16'h0000
`define REC_RST_CAPTURE     16'h0000
`define REC_RST_INT_ENABLE  16'h0000
`define REC_RST_RDATA       16'h0000
`define REC_RST_PIN_N       1'h1
`define REC_RST_BUS_LEVEL   1'h0
`define REC_RST_IRQ         1'h0

`endif

// file: logic/rec_edge_detect.v
`timescale 1ns/1ps
`include "rec_defines.vh"

module rec_edge_detect #(
  parameter CHANNELS = 16
) (
  input  wire                sys_clk,
  input  wire                sys_rst,
  input  wire [CHANNELS-1:0] pin_n,
  input  wire [CHANNELS-1:0] polarity,
  output wire [CHANNELS-1:0] edge_hit
);

  genvar i;
  generate
    for (i = 0; i < CHANNELS; i = i + 1) begin : g_chan
      reg meta_q;
      reg sync_q;
      reg prev_q;
      wire cur_lvl;
      wire prv_lvl;

      // two-flop synchroniser on the raw pin
      always @(posedge sys_clk) begin
        if (sys_rst) begin
          meta_q <= `REC_RST_PIN_N;
          sync_q <= `REC_RST_PIN_N;
          prev_q <= `REC_RST_PIN_N;
        end else begin
          meta_q <= pin_n[i];
          sync_q <= meta_q;
          prev_q <= sync_q;
        end
      end

      // bus-side value is the inverted pin level
      assign cur_lvl = ~sync_q;
      assign prv_lvl = ~prev_q;

      // one selects rising, zero selects falling
      assign edge_hit[i] = polarity[i] ? (cur_lvl & ~prv_lvl)
                                       : (~cur_lvl & prv_lvl);
    end
  endgenerate

endmodule // rec_edge_detect

// file: logic/rec_top.v
// How it works
// - only channels 0 to 15 get edge detection, capture and interrupt; no other channel is handled here.
// - the write-only polarity word picks rising (one) or falling (zero) edges per channel.
// - edges are judged on the bus-side value, not on the inverted connector level.
// - writing the arm port sets capture enable for each one bit and leaves zero bits alone.
// - a capture flag sets when the selected edge occurs on an armed channel only.
// - reading the capture port returns all sixteen flags, channel n in bit n.
// - a set capture flag stays set until the host disarms that channel.
// - writing the disarm port clears capture enable for each one bit, and the flag unless a fresh edge hits that cycle; several at once allowed.
// - a write to the capture offset loads the per-channel interrupt enable word.
// - changing interrupt enables leaves capture flags and capture enables alone.
// - a channel requests an interrupt only while armed, captured and enabled.
// - disarming the requesting channel always withdraws its request, and clears its flag unless a fresh edge hits in the same cycle.
// - channel values are active high on the bus and active low at the pins.
// - the read-only status word shows the relay service request in bit 11.
`timescale 1ns/1ps
`include "rec_defines.vh"

module rec_top #(
  parameter CHANNELS = 16
) (
  input  wire                sys_clk,
  input  wire                sys_rst,
  input  wire [5:0]          bus_addr,
  input  wire                bus_wr,
  input  wire                bus_rd,
  input  wire [15:0]         bus_wdata,
  output wire [15:0]         bus_rdata,
  output wire                bus_irq,
  input  wire [CHANNELS-1:0] relay_pin_n
);

  // reset words, one bit per channel
  localparam [15:0] RST_POL_WORD = `REC_RST_POLARITY;
  localparam [15:0] RST_ARM_WORD = `REC_RST_ARM;
  localparam [15:0] RST_CAP_WORD = `REC_RST_CAPTURE;
  localparam [15:0] RST_IEN_WORD = `REC_RST_INT_ENABLE;

  // register slot codes after address decode
  localparam [2:0] SEL_NONE     = 3'h0;
  localparam [2:0] SEL_SHARED   = 3'h1;
  localparam [2:0] SEL_STATUS   = 3'h2;
  localparam [2:0] SEL_POLARITY = 3'h3;
  localparam [2:0] SEL_DISARM   = 3'h4;
  localparam [2:0] SEL_ARM      = 3'h5;

  reg  [2:0]          reg_sel;
  reg  [15:0]         rdata_q;
  reg  [15:0]         rdata_d;
  reg                 irq_q;
  reg                 irq_d;
  wire [CHANNELS-1:0] edge_hit;
  wire [CHANNELS-1:0] polarity;
  wire [CHANNELS-1:0] captured;
  wire [CHANNELS-1:0] request;
  wire                relay_service_request_flag;
  wire                wr_polarity;
  wire                wr_int_enable;
  wire                wr_arm;
  wire                wr_disarm;
  wire                rd_capture;
  wire                rd_status;

  // only the sixteen enhanced channels exist in this block
  rec_edge_detect #(
    .CHANNELS (CHANNELS)
  ) u_edge (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .pin_n    (relay_pin_n),
    .polarity (polarity),
    .edge_hit (edge_hit)
  );

  // one slot per offset; capture read and enable write share a slot
  always @* begin
    reg_sel = SEL_NONE;
    case (bus_addr)
      `REC_OFS_CAPTURE: begin
        reg_sel = SEL_SHARED;
      end
      `REC_OFS_STATUS: begin
        reg_sel = SEL_STATUS;
      end
      `REC_OFS_POLARITY: begin
        reg_sel = SEL_POLARITY;
      end
      `REC_OFS_DISARM: begin
        reg_sel = SEL_DISARM;
      end
      `REC_OFS_ARM: begin
        reg_sel = SEL_ARM;
      end
      default: begin
        reg_sel = SEL_NONE;
      end
    endcase
  end

  // status is read only; writes to it fall through
  assign wr_polarity   = bus_wr & (reg_sel == SEL_POLARITY);
  assign wr_int_enable = bus_wr & (reg_sel == SEL_SHARED);
  assign wr_arm        = bus_wr & (reg_sel == SEL_ARM);
  assign wr_disarm     = bus_wr & (reg_sel == SEL_DISARM);
  assign rd_capture    = bus_rd & (reg_sel == SEL_SHARED);
  assign rd_status     = bus_rd & (reg_sel == SEL_STATUS);

  // per channel state
  genvar i;
  generate
    for (i = 0; i < CHANNELS; i = i + 1) begin : g_slot
      reg  pol_q;
      reg  ien_q;
      reg  arm_q;
      reg  arm_d;
      reg  cap_q;
      reg  cap_d;
      wire set_arm;
      wire clr_chan;
      wire hit;

      assign set_arm  = wr_arm & bus_wdata[i];
      assign clr_chan = wr_disarm & bus_wdata[i];
      assign hit      = edge_hit[i] & arm_q;

      // edge polarity: one rising, zero falling
      always @(posedge sys_clk) begin
        if (sys_rst) begin
          pol_q <= RST_POL_WORD[i];
        end else if (wr_polarity) begin
          pol_q <= bus_wdata[i];
        end
      end

      // enable bit never touches arm or capture
      always @(posedge sys_clk) begin
        if (sys_rst) begin
          ien_q <= RST_IEN_WORD[i];
        end else if (wr_int_enable) begin
          ien_q <= bus_wdata[i];
        end
      end

      // zero bits of an arm or disarm write leave the channel alone
      always @* begin
        arm_d = arm_q;
        if (clr_chan) begin
          arm_d = 1'h0;
        end else if (set_arm) begin
          arm_d = 1'h1;
        end
      end

      always @(posedge sys_clk) begin
        if (sys_rst) begin
          arm_q <= RST_ARM_WORD[i];
        end else begin
          arm_q <= arm_d;
        end
      end

      // a fresh edge beats a disarm in the same cycle
      always @* begin
        cap_d = cap_q;
        if (hit) begin
          cap_d = 1'h1;
        end else if (clr_chan) begin
          cap_d = 1'h0;
        end
      end

      always @(posedge sys_clk) begin
        if (sys_rst) begin
          cap_q <= RST_CAP_WORD[i];
        end else begin
          cap_q <= cap_d;
        end
      end

      assign polarity[i] = pol_q;
      assign captured[i] = cap_q;
      // request needs armed, captured and enabled
      assign request[i]  = arm_q & cap_q & ien_q;
    end
  endgenerate

  assign relay_service_request_flag = |request;

  // read word: flags, status bit, or zero for any other offset
  always @* begin
    rdata_d = 16'h0000;
    if (rd_capture) begin
      rdata_d[CHANNELS-1:0] = captured;
    end else if (rd_status) begin
      rdata_d[`REC_STATUS_REQ_BIT] = relay_service_request_flag;
    end
  end

  // read data holds until the next read
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_q <= `REC_RST_RDATA;
    end else if (bus_rd) begin
      rdata_q <= rdata_d;
    end
  end

  always @* begin
    irq_d = relay_service_request_flag;
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_q <= `REC_RST_IRQ;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign bus_rdata = rdata_q;
  assign bus_irq   = irq_q;

endmodule // rec_top

// file: verif/rec_relay_model.sv
`timescale 1ns/1ps
module rec_relay_model (
  input  wire [15:0] bus_level,
  output wire [15:0] relay_pin_n
);
  assign relay_pin_n = ~bus_level;
endmodule // rec_relay_model

// file: verif/rec_checker.sv
`timescale 1ns/1ps
module rec_checker (
  input wire        sys_clk,
  input wire        sys_rst,
  input wire [5:0]  bus_addr,
  input wire        bus_wr,
  input wire        bus_rd,
  input wire [15:0] bus_wdata,
  input wire [15:0] bus_rdata,
  input wire        bus_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire en_wr = bus_wr && bus_addr == 6'h1E;
  wire clr = en_wr || (bus_wr && bus_addr == 6'h24);
  wire off = en_wr && bus_wdata == 16'h0000;
  property p_req; bus_rd && bus_addr == 6'h16 |=> bus_rdata == {4'h0, bus_irq, 11'h000}; endproperty
  a_req: assert property (p_req) else $error("bad status word");
  property p_stick; bus_irq && !clr && !$past(clr) |=> bus_irq; endproperty
  a_stick: assert property (p_stick) else $error("irq lost");
  property p_off; off ##1 !bus_wr |=> !bus_irq; endproperty
  a_off: assert property (p_off) else $error("irq not masked");
  property p_drop; bus_wr && bus_addr == 6'h24 && bus_wdata == 16'hFFFF ##1 !bus_wr |=> !bus_irq; endproperty
  a_drop: assert property (p_drop) else $error("irq not withdrawn");
  property p_back; bus_irq && !clr && !$past(clr) ##1 off ##1 !bus_wr ##1 en_wr && bus_wdata == 16'hFFFF
    |-> ##2 bus_irq; endproperty
  a_back: assert property (p_back) else $error("irq not restored");
  property p_hold; !bus_rd |=> $stable(bus_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  c_irq: cover property ($rose(bus_irq));
  c_st: cover property (bus_rd && bus_addr == 6'h16);
  c_off: cover property (off);
endmodule // rec_checker
bind rec_top rec_checker chk (.*);

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk = 1'b0, sys_rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0;
  logic [5:0]  bus_addr = 6'h00;
  logic [15:0] bus_wdata = 16'h0000, lvl = 16'h0000;
  wire  [15:0] bus_rdata, relay_pin_n;
  wire         bus_irq;
  int          err_total = 0, checks_done = 0, cyc = 0;
  always #2 sys_clk = ~sys_clk;
  rec_relay_model rack (.bus_level(lvl), .relay_pin_n(relay_pin_n));
  rec_top dut (.*);
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(logic w, logic [5:0] a, logic [15:0] d);
    @(posedge sys_clk);
    bus_wr <= w;
    bus_rd <= !w;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    #1;
  endtask
  task automatic pins(logic [15:0] v);
    @(posedge sys_clk);
    lvl <= v;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic t_capture;
    bus(1'b1, 6'h22, 16'h0005);
    bus(1'b1, 6'h26, 16'h0007);
    bus(1'b1, 6'h1E, 16'h0001);
    pins(16'h000A);
    pins(16'h0005);
    bus(1'b0, 6'h1E, 16'h0000);
    check("flags", bus_rdata, 16'h0007);
    check("irq", 16'(bus_irq), 16'h0001);
    $display("capture test done");
  endtask
  task automatic t_service;
    bus(1'b1, 6'h1E, 16'h0000);
    bus(1'b1, 6'h1E, 16'hFFFF);
    check("masked irq", 16'(bus_irq), 16'h0000);
    tick;
    check("restored irq", 16'(bus_irq), 16'h0001);
    pins(16'h0000);
    bus(1'b0, 6'h1E, 16'h0000);
    check("sticky flags", bus_rdata, 16'h0007);
    bus(1'b1, 6'h24, 16'h0003);
    bus(1'b0, 6'h16, 16'h0000);
    check("status", bus_rdata, 16'h0800);
    bus(1'b0, 6'h00, 16'h0000);
    check("unmapped", bus_rdata, 16'h0000);
    bus(1'b0, 6'h1E, 16'h0000);
    check("part clear", bus_rdata, 16'h0004);
    bus(1'b1, 6'h24, 16'hFFFF);
    bus(1'b0, 6'h1E, 16'h0000);
    check("irq off", 16'(bus_irq), 16'h0000);
    check("cleared flags", bus_rdata, 16'h0000);
    $display("service test done");
  endtask
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic t_rearm;
    bus(1'b1, 6'h26, 16'h0001);
    pins(16'h0005);
    bus(1'b0, 6'h1E, 16'h0000);
    check("rearmed flags", bus_rdata, 16'h0001);
    check("rearmed irq", 16'(bus_irq), 16'h0001);
    bus(1'b1, 6'h24, 16'h0001);
    bus(1'b0, 6'h1E, 16'h0000);
    check("serviced flags", bus_rdata, 16'h0000);
    check("serviced irq", 16'(bus_irq), 16'h0000);
    $display("rearm test done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      err_total++;
      report_and_stop;
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_capture;
    t_service;
    t_rearm;
    report_and_stop;
  end
endmodule // tb_top
